// File: logic/trap_trigger_csr_bank.sv
`timescale 1ns/1ns
`default_nettype none
module trap_trigger_csr_bank
  import trap_csr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic debug_mode,
  input wire logic trap_enter,
  input wire logic trap_is_irq,
  input wire logic [30:0] trap_code,
  input wire logic [31:0] trap_pc,
  input wire logic [31:0] trap_next_pc,
  input wire logic [31:0] trap_value_in,
  input wire logic trap_return,
  input wire logic debug_enter,
  input wire logic [1:0] debug_cause,
  input wire logic [31:0] debug_pc,
  input wire logic [31:0] debug_next_pc,
  input wire logic irq_pending,
  input wire logic nmi_pending,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  input wire logic store_valid,
  input wire logic [31:0] store_addr,
  input wire logic load_valid,
  input wire logic [31:0] load_addr,
  output logic [31:0] resume_pc,
  output logic [31:0] debug_resume_pc,
  output logic priv_machine,
  output logic irq_take,
  output logic nmi_take,
  output logic bp_exception,
  output logic debug_request
);

  // ==========================================
  // state
  typedef enum logic [0:0] {
    BUS_WAIT = 1'b1,
    BUS_ACK = 1'b0
  } bus_state_t;

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] readdata;
    logic priv_machine;
    logic machine_irq_enable;
    logic prior_irq_enable;
    logic [1:0] mpp;
    logic [31:0] scratch;
    logic [31:0] epc;
    logic [31:0] cause;
    logic [31:0] tval;
    logic [1:0] tsel;
    logic [3:0][6:0] ctl;
    logic [3:0][31:0] tmatch;
    logic [1:0][31:0] dbg_scr;
    logic [31:0] prot_cfg;
    logic [31:0] prot_addr;
    logic [31:0] dpc;
    logic irq_take;
    logic nmi_take;
    logic bp_exception;
    logic debug_request;
  } state_t;

  state_t state_q;
  state_t state_d;

  // ==========================================
  // helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // stored control bits: {hit_a, match, m, u, exec, store, load}
  function automatic logic [31:0] ctl_word(input logic [6:0] c);
    logic [31:0] w;
    w = RESET_WORD;
    w[TC_TYPE_LO +: 4] = TRIG_TYPE_VALUE;
    w[TC_DEBUG_ONLY_BIT] = DEBUG_ONLY_WRITE_VALUE;
    w[TC_MAX_MASK_LO +: 6] = MAX_MASK_EXPONENT_VALUE;
    w[TC_HIT_A_BIT] = c[6];
    w[TC_MATCH_BIT] = c[5];
    w[TC_M_BIT] = c[4];
    w[TC_U_BIT] = c[3];
    w[TC_EXEC_BIT] = c[2];
    w[TC_STORE_BIT] = c[1];
    w[TC_LOAD_BIT] = c[0];
    return w;
  endfunction

  // masked compare ignores bits up to and including the lowest zero of val
  function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] val, input logic masked);
    logic [31:0] care;
    care = masked ? ~(val ^ (val + 32'h0000_0001)) : 32'hFFFF_FFFF;
    return ((addr ^ val) & care) == 32'h0000_0000;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic machine_ok;
    logic accept;
    logic wr_go;
    logic [31:0] rd_val;
    logic [31:0] wv;
    logic [6:0] c;
    logic [31:0] tm;
    logic hit;
    logic any_bp;
    logic any_dbg;
    rd_val = RESET_WORD;
    wv = RESET_WORD;
    c = 7'h00;
    tm = RESET_WORD;
    hit = 1'b0;
    any_bp = 1'b0;
    any_dbg = 1'b0;
    state_d = state_q;
    machine_ok = state_q.priv_machine | debug_mode;
    accept = (read | write) && (state_q.bus == BUS_WAIT);
    wr_go = write && (state_q.bus == BUS_ACK);

    // read mux, denied or unmapped reads return zero
    unique case (address)
      OFF_ISA: rd_val = ISA_VALUE;
      OFF_STATUS: begin
        rd_val[STAT_IRQ_EN_BIT] = state_q.machine_irq_enable;
        rd_val[STAT_PRIOR_EN_BIT] = state_q.prior_irq_enable;
        rd_val[STAT_MPP_LO +: 2] = state_q.mpp;
        if (!machine_ok) rd_val = RESET_WORD;
      end
      OFF_TRAP_SCRATCH: rd_val = machine_ok ? state_q.scratch : RESET_WORD;
      OFF_TRAP_RETURN_PC: rd_val = machine_ok ? state_q.epc : RESET_WORD;
      OFF_TRAP_CAUSE: rd_val = machine_ok ? state_q.cause : RESET_WORD;
      OFF_TRAP_VALUE: rd_val = machine_ok ? state_q.tval : RESET_WORD;
      OFF_TRIGGER_SELECT: rd_val[1:0] = machine_ok ? state_q.tsel : 2'h0;
      OFF_TRIGGER_CONTROL: rd_val = machine_ok ? ctl_word(state_q.ctl[state_q.tsel]) : RESET_WORD;
      OFF_TRIGGER_MATCH: rd_val = machine_ok ? state_q.tmatch[state_q.tsel] : RESET_WORD;
      OFF_DEBUG_SCRATCH0: rd_val = debug_mode ? state_q.dbg_scr[0] : RESET_WORD;
      OFF_DEBUG_SCRATCH1: rd_val = debug_mode ? state_q.dbg_scr[1] : RESET_WORD;
      OFF_PROT_CFG: rd_val = machine_ok ? state_q.prot_cfg : RESET_WORD;
      OFF_PROT_ADDR: rd_val = machine_ok ? state_q.prot_addr : RESET_WORD;
      OFF_DEBUG_RESUME_PC: rd_val = debug_mode ? state_q.dpc : RESET_WORD;
      OFF_GLOBAL_IRQ_EN: begin
        rd_val[STAT_IRQ_EN_BIT] = state_q.machine_irq_enable;
        rd_val[STAT_PRIOR_EN_BIT] = state_q.prior_irq_enable;
      end
      default: rd_val = RESET_WORD;
    endcase

    // bus handshake: one wait cycle, then one acknowledge cycle
    if (accept) begin
      state_d.bus = BUS_ACK;
      state_d.readdata = rd_val;
    end else begin
      state_d.bus = BUS_WAIT;
    end

    // register writes; reserved and fixed bits are dropped
    if (wr_go) begin
      unique case (address)
        OFF_STATUS: begin
          if (machine_ok) begin
            wv = be_merge(RESET_WORD, writedata, byteenable);
            if (byteenable[0]) state_d.machine_irq_enable = writedata[STAT_IRQ_EN_BIT];
            if (byteenable[0]) state_d.prior_irq_enable = writedata[STAT_PRIOR_EN_BIT];
            if (byteenable[1]) state_d.mpp = wv[STAT_MPP_LO +: 2];
          end
        end
        OFF_TRAP_SCRATCH: if (machine_ok) state_d.scratch = be_merge(state_q.scratch, writedata, byteenable);
        // software may move the return point
        OFF_TRAP_RETURN_PC: if (machine_ok) state_d.epc = be_merge(state_q.epc, writedata, byteenable);
        OFF_TRAP_CAUSE: if (machine_ok) state_d.cause = be_merge(state_q.cause, writedata, byteenable);
        OFF_TRAP_VALUE: if (machine_ok) state_d.tval = be_merge(state_q.tval, writedata, byteenable);
        OFF_TRIGGER_SELECT: if (machine_ok && byteenable[0]) state_d.tsel = writedata[1:0];
        OFF_TRIGGER_CONTROL: begin
          // debug mode only, fixed fields ignored
          if (debug_mode) begin
            wv = be_merge(ctl_word(state_q.ctl[state_q.tsel]), writedata, byteenable);
            state_d.ctl[state_q.tsel] = {wv[TC_HIT_A_BIT], wv[TC_MATCH_BIT], wv[TC_M_BIT], wv[TC_U_BIT],
                                         wv[TC_EXEC_BIT], wv[TC_STORE_BIT], wv[TC_LOAD_BIT]};
          end
        end
        OFF_TRIGGER_MATCH: begin
          if (debug_mode) begin
            state_d.tmatch[state_q.tsel] = be_merge(state_q.tmatch[state_q.tsel], writedata, byteenable);
          end
        end
        OFF_DEBUG_SCRATCH0: if (debug_mode) state_d.dbg_scr[0] = be_merge(state_q.dbg_scr[0], writedata, byteenable);
        OFF_DEBUG_SCRATCH1: if (debug_mode) state_d.dbg_scr[1] = be_merge(state_q.dbg_scr[1], writedata, byteenable);
        OFF_PROT_CFG: if (machine_ok) state_d.prot_cfg = be_merge(state_q.prot_cfg, writedata, byteenable);
        OFF_PROT_ADDR: if (machine_ok) state_d.prot_addr = be_merge(state_q.prot_addr, writedata, byteenable);
        OFF_DEBUG_RESUME_PC: if (debug_mode) state_d.dpc = be_merge(state_q.dpc, writedata, byteenable);
        OFF_GLOBAL_IRQ_EN: begin
          if (byteenable[0]) begin
            state_d.machine_irq_enable = writedata[STAT_IRQ_EN_BIT];
            state_d.prior_irq_enable = writedata[STAT_PRIOR_EN_BIT];
          end
        end
        default: state_d.readdata = state_q.readdata;
      endcase
    end

    // hardware events take priority over a bus write in the same cycle
    if (trap_enter) begin
      state_d.epc = trap_is_irq ? trap_next_pc : trap_pc;
      state_d.cause = {trap_is_irq, trap_code};
      if (!trap_is_irq) state_d.tval = trap_value_in;
      state_d.prior_irq_enable = state_q.machine_irq_enable;
      state_d.mpp = state_q.priv_machine ? PRIV_MACHINE : PRIV_USER;
      state_d.priv_machine = 1'b1;
    end else if (trap_return) begin
      state_d.machine_irq_enable = state_q.prior_irq_enable;
      state_d.priv_machine = (state_q.mpp == PRIV_MACHINE);
    end

    if (debug_enter) begin
      state_d.dpc = (debug_cause == DBG_EBREAK) ? debug_pc : debug_next_pc;
    end

    state_d.irq_take = irq_pending & state_q.machine_irq_enable;
    state_d.nmi_take = nmi_pending;

    // trigger channels
    for (int i = 0; i < NUM_TRIG; i++) begin
      c = state_q.ctl[i];
      tm = state_q.tmatch[i];
      hit = (c[2] & fetch_valid & addr_hit(fetch_addr, tm, c[5]))
          | (c[1] & store_valid & addr_hit(store_addr, tm, c[5]))
          | (c[0] & load_valid & addr_hit(load_addr, tm, c[5]));
      hit = hit & (state_q.priv_machine ? c[4] : c[3]) & ~debug_mode;
      any_bp = any_bp | (hit & ~c[6]);
      any_dbg = any_dbg | (hit & c[6]);
    end
    state_d.bp_exception = any_bp;
    state_d.debug_request = any_dbg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= '0;
      state_q.bus <= BUS_WAIT;
      state_q.priv_machine <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================
  // outputs
  assign readdata = state_q.readdata;
  assign waitrequest = state_q.bus;
  assign resume_pc = state_q.epc;
  assign debug_resume_pc = state_q.dpc;
  assign priv_machine = state_q.priv_machine;
  assign irq_take = state_q.irq_take;
  assign nmi_take = state_q.nmi_take;
  assign bp_exception = state_q.bp_exception;
  assign debug_request = state_q.debug_request;

  // ==========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_rd_req(logic [7:0] off);
    read && waitrequest && address == off;
  endsequence

  sequence s_full_wr(logic [7:0] off);
    write && !waitrequest && address == off && byteenable == 4'hF;
  endsequence

  property p_isa;
    s_rd_req(OFF_ISA) |=> readdata == ISA_VALUE && !waitrequest;
  endproperty
  a_isa: assert property (p_isa) else $error("isa descriptor wrong");

  property p_scratch;
    s_full_wr(OFF_TRAP_SCRATCH) ##0 priv_machine |=> state_q.scratch == $past(writedata);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch write lost");

  property p_exc_pc;
    trap_enter && !trap_is_irq |=> resume_pc == $past(trap_pc) && state_q.tval == $past(trap_value_in);
  endproperty
  a_exc_pc: assert property (p_exc_pc) else $error("exception return pc or value wrong");

  property p_irq_pc;
    trap_enter && trap_is_irq |=> resume_pc == $past(trap_next_pc);
  endproperty
  a_irq_pc: assert property (p_irq_pc) else $error("interrupt return pc wrong");

  property p_sw_epc;
    s_full_wr(OFF_TRAP_RETURN_PC) ##0 (priv_machine && !trap_enter) |=> resume_pc == $past(writedata);
  endproperty
  a_sw_epc: assert property (p_sw_epc) else $error("software return pc not used");

  property p_cause;
    trap_enter |=> state_q.cause[CAUSE_IRQ_BIT] == $past(trap_is_irq) && state_q.cause[30:0] == $past(trap_code);
  endproperty
  a_cause: assert property (p_cause) else $error("cause word wrong");

  property p_tsel_rd;
    s_rd_req(OFF_TRIGGER_SELECT) |=> readdata[31:2] == 30'h0;
  endproperty
  a_tsel_rd: assert property (p_tsel_rd) else $error("select upper bits not zero");

  property p_tctl_rd;
    s_rd_req(OFF_TRIGGER_CONTROL) ##0 priv_machine
      |=> readdata[31:21] == {TRIG_TYPE_VALUE, DEBUG_ONLY_WRITE_VALUE, MAX_MASK_EXPONENT_VALUE};
  endproperty
  a_tctl_rd: assert property (p_tctl_rd) else $error("fixed control fields wrong");

  property p_tctl_lock;
    write && !waitrequest && !debug_mode |=> $stable(state_q.ctl) && $stable(state_q.tmatch);
  endproperty
  a_tctl_lock: assert property (p_tctl_lock) else $error("trigger changed outside debug");

  property p_dscr_lock;
    write && !waitrequest && !debug_mode |=> $stable(state_q.dbg_scr);
  endproperty
  a_dscr_lock: assert property (p_dscr_lock) else $error("debug scratch changed outside debug");

  property p_nmi;
    nmi_pending && !state_q.machine_irq_enable |=> nmi_take && !irq_take;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi gated by enable");

  property p_dpc;
    debug_enter && debug_cause == DBG_EBREAK |=> debug_resume_pc == $past(debug_pc);
  endproperty
  a_dpc: assert property (p_dpc) else $error("debug resume pc wrong");

  property p_prior;
    trap_enter |=> state_q.prior_irq_enable == $past(state_q.machine_irq_enable) && priv_machine;
  endproperty
  a_prior: assert property (p_prior) else $error("prior enable not saved");

endmodule
`default_nettype wire

// File: logic/trap_csr_pkg.sv
package trap_csr_pkg;

  // ==========================================
  // register map, byte addresses of 32-bit words
  localparam logic [7:0] OFF_ISA = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TRAP_SCRATCH = 8'h08;
  localparam logic [7:0] OFF_TRAP_RETURN_PC = 8'h0C;
  localparam logic [7:0] OFF_TRAP_CAUSE = 8'h10;
  localparam logic [7:0] OFF_TRAP_VALUE = 8'h14;
  localparam logic [7:0] OFF_TRIGGER_SELECT = 8'h18;
  localparam logic [7:0] OFF_TRIGGER_CONTROL = 8'h1C;
  localparam logic [7:0] OFF_TRIGGER_MATCH = 8'h20;
  localparam logic [7:0] OFF_DEBUG_SCRATCH0 = 8'h24;
  localparam logic [7:0] OFF_DEBUG_SCRATCH1 = 8'h28;
  localparam logic [7:0] OFF_DEBUG_RESUME_PC = 8'h2C;
  localparam logic [7:0] OFF_GLOBAL_IRQ_EN = 8'h30;
  localparam logic [7:0] OFF_PROT_CFG = 8'h34;
  localparam logic [7:0] OFF_PROT_ADDR = 8'h38;

  // ==========================================
  // fixed values and reset values
  localparam logic [31:0] ISA_VALUE = 32'h4010_1105;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] TRIG_TYPE_VALUE = 4'h2;
  localparam logic [0:0] DEBUG_ONLY_WRITE_VALUE = 1'h1;
  localparam logic [5:0] MAX_MASK_EXPONENT_VALUE = 6'h1F;
  localparam logic [1:0] PRIV_MACHINE = 2'h3;
  localparam logic [1:0] PRIV_USER = 2'h0;

  // ==========================================
  // status, alias and cause field positions
  localparam int unsigned STAT_IRQ_EN_BIT = 3;
  localparam int unsigned STAT_PRIOR_EN_BIT = 7;
  localparam int unsigned STAT_MPP_LO = 11;
  localparam int unsigned CAUSE_IRQ_BIT = 31;

  // ==========================================
  // trigger control field positions
  localparam int unsigned TC_TYPE_LO = 28;
  localparam int unsigned TC_DEBUG_ONLY_BIT = 27;
  localparam int unsigned TC_MAX_MASK_LO = 21;
  localparam int unsigned TC_HIT_A_BIT = 12;
  localparam int unsigned TC_MATCH_BIT = 7;
  localparam int unsigned TC_M_BIT = 6;
  localparam int unsigned TC_U_BIT = 3;
  localparam int unsigned TC_EXEC_BIT = 2;
  localparam int unsigned TC_STORE_BIT = 1;
  localparam int unsigned TC_LOAD_BIT = 0;
  localparam int unsigned NUM_TRIG = 4;

  // ==========================================
  // debug entry causes
  typedef enum logic [1:0] {
    DBG_EBREAK = 2'b00,
    DBG_STEP = 2'b01,
    DBG_HALT = 2'b10
  } debug_cause_t;

endpackage

// File: testbench/core_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_side_model (
  input wire logic clk,
  output logic debug_mode = 1'b0,
  output logic trap_enter = 1'b0,
  output logic trap_is_irq = 1'b0,
  output logic [30:0] trap_code = 31'h0000_0000,
  output logic [31:0] trap_pc = 32'h0000_0000,
  output logic [31:0] trap_next_pc = 32'h0000_0000,
  output logic [31:0] trap_value_in = 32'h0000_0000,
  output logic trap_return = 1'b0,
  output logic debug_enter = 1'b0,
  output logic [1:0] debug_cause = 2'h0,
  output logic [31:0] debug_pc = 32'h0000_0000,
  output logic [31:0] debug_next_pc = 32'h0000_0000,
  output logic irq_pending = 1'b0,
  output logic nmi_pending = 1'b0,
  output logic fetch_valid = 1'b0,
  output logic [31:0] fetch_addr = 32'h0000_0000,
  output logic store_valid = 1'b0,
  output logic [31:0] store_addr = 32'h0000_0000,
  output logic load_valid = 1'b0,
  output logic [31:0] load_addr = 32'h0000_0000
);
  // ==========================================
  // mode and pending levels
  task automatic set_dbg(input logic v);
    @(posedge clk);
    debug_mode <= v;
  endtask
  task automatic set_lv(input logic i, input logic n);
    @(posedge clk);
    irq_pending <= i;
    nmi_pending <= n;
  endtask
  // ==========================================
  // trap entry and return pulses, data inverted once released
  // faulting and following address
  task automatic trap(input logic irq, input logic [30:0] c, input logic [31:0] p, input logic [31:0] np,
      input logic [31:0] v);
    @(posedge clk);
    trap_enter <= 1'b1;
    trap_is_irq <= irq;
    trap_code <= c;
    trap_pc <= p;
    trap_next_pc <= np;
    trap_value_in <= v;
    @(posedge clk);
    trap_enter <= 1'b0;
    trap_code <= ~c;
    trap_pc <= ~p;
    trap_next_pc <= ~np;
    trap_value_in <= ~v;
  endtask
  task automatic ret();
    @(posedge clk);
    trap_return <= 1'b1;
    @(posedge clk);
    trap_return <= 1'b0;
  endtask
  // current and next address
  task automatic dent(input logic [1:0] c, input logic [31:0] p, input logic [31:0] np);
    @(posedge clk);
    debug_enter <= 1'b1;
    debug_cause <= c;
    debug_pc <= p;
    debug_next_pc <= np;
    @(posedge clk);
    debug_enter <= 1'b0;
    debug_pc <= ~p;
    debug_next_pc <= ~np;
  endtask
  // ==========================================
  // one-cycle access: 0 fetch, 1 store, 2 load
  task automatic acc(input int k, input logic [31:0] a);
    @(posedge clk);
    fetch_valid <= (k == 0);
    store_valid <= (k == 1);
    load_valid <= (k == 2);
    fetch_addr <= a;
    store_addr <= a;
    load_addr <= a;
    @(posedge clk);
    fetch_valid <= 1'b0;
    store_valid <= 1'b0;
    load_valid <= 1'b0;
    fetch_addr <= ~a;
    store_addr <= ~a;
    load_addr <= ~a;
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_trap_and_trigger_csr_bank.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_trap_and_trigger_csr_bank;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata, resume_pc, debug_resume_pc, trap_pc, trap_next_pc, trap_value_in, debug_pc, debug_next_pc;
  logic [31:0] fetch_addr, store_addr, load_addr;
  logic [30:0] trap_code;
  logic [1:0] debug_cause;
  logic waitrequest, priv_machine, irq_take, nmi_take, bp_exception, debug_request, debug_mode, trap_enter;
  logic trap_is_irq, trap_return, debug_enter, irq_pending, nmi_pending, fetch_valid, store_valid, load_valid;
  logic pm = 1'b1;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] m [0:15];
  logic [31:0] tc [0:3];
  logic [31:0] tm [0:3];
  logic [31:0] ha [0:2];
  logic [31:0] ma [0:2];
  trap_trigger_csr_bank uut (.clk, .reset, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .debug_mode, .trap_enter, .trap_is_irq, .trap_code, .trap_pc, .trap_next_pc, .trap_value_in,
    .trap_return, .debug_enter, .debug_cause, .debug_pc, .debug_next_pc, .irq_pending, .nmi_pending,
    .fetch_valid, .fetch_addr, .store_valid, .store_addr, .load_valid, .load_addr, .resume_pc,
    .debug_resume_pc, .priv_machine, .irq_take, .nmi_take, .bp_exception, .debug_request);
  core_side_model u_core (.clk, .debug_mode, .trap_enter, .trap_is_irq, .trap_code, .trap_pc, .trap_next_pc,
    .trap_value_in, .trap_return, .debug_enter, .debug_cause, .debug_pc, .debug_next_pc, .irq_pending,
    .nmi_pending, .fetch_valid, .fetch_addr, .store_valid, .store_addr, .load_valid, .load_addr);
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========================================
  // reference model of the register bank
  function automatic logic [31:0] wmask(logic [7:0] a);
    logic mach;
    mach = pm || debug_mode;
    case (a)
      8'h04: return mach ? 32'h0000_1888 : ZERO;
      8'h08, 8'h0C, 8'h10, 8'h14, 8'h34, 8'h38: return mach ? ONES : ZERO;
      8'h18: return mach ? 32'h0000_0003 : ZERO;
      8'h1C: return debug_mode ? 32'h0000_10CF : ZERO;
      8'h20, 8'h24, 8'h28, 8'h2C: return debug_mode ? ONES : ZERO;
      8'h30: return 32'h0000_0088;
      default: return ZERO;
    endcase
  endfunction
  function automatic logic [31:0] expr(logic [7:0] a);
    logic mach;
    mach = pm || debug_mode;
    case (a)
      8'h00: return 32'h4010_1105;
      8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h34, 8'h38: return mach ? m[a[5:2]] : ZERO;
      8'h1C: return mach ? (32'h2BE0_0000 | tc[m[6][1:0]]) : ZERO;
      8'h20: return mach ? tm[m[6][1:0]] : ZERO;
      8'h24, 8'h28, 8'h2C: return debug_mode ? m[a[5:2]] : ZERO;
      8'h30: return m[1] & 32'h0000_0088;
      default: return ZERO;
    endcase
  endfunction
  // expected {bp_exception, debug_request} for one access kind
  function automatic logic [1:0] fire(int kind, logic [31:0] a);
    logic [1:0] r;
    logic [31:0] msk;
    int n;
    r = 2'b00;
    for (int ch = 0; ch < 4; ch++) begin
      n = 0;
      while (tc[ch][7] && tm[ch][n] && n < 31) n++;
      msk = tc[ch][7] ? (ONES << (n + 1)) : ONES;
      if (tc[ch][2 - kind] && (pm ? tc[ch][6] : tc[ch][3]) && ((a ^ tm[ch]) & msk) == ZERO)
        r = r | (tc[ch][12] ? 2'b01 : 2'b10);
    end
    return r;
  endfunction
  // ==========================================
  // avalon master
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 100) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q, k;
    bus(1'b1, a, d, q);
    k = wmask(a);
    if (a == 8'h1C) tc[m[6][1:0]] = (tc[m[6][1:0]] & ~k) | (d & k);
    else if (a == 8'h20) tm[m[6][1:0]] = (tm[m[6][1:0]] & ~k) | (d & k);
    else if (a == 8'h30) m[1] = (m[1] & ~k) | (d & k);
    else m[a[5:2]] = (m[a[5:2]] & ~k) | (d & k);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] q;
    bus(1'b0, a, ZERO, q);
    `CHK(q, expr(a))
  endtask
  task automatic take_trap(input logic irq);
    logic [31:0] p, v;
    logic [30:0] c;
    p = $urandom();
    v = $urandom();
    c = 31'($urandom());
    u_core.trap(irq, c, p, p + 32'h0000_0004, v);
    m[3] = irq ? p + 32'h0000_0004 : p;
    m[4] = {irq, c};
    if (!irq) m[5] = v;
    m[1][7] = m[1][3];
    m[1][12:11] = pm ? 2'b11 : 2'b00;
    pm = 1'b1;
    #1;
    `CHK(resume_pc, m[3])
    rd(8'h0C);
    rd(8'h10);
    rd(8'h14);
    rd(8'h30);
    rd(8'h04);
  endtask
  task automatic take_ret();
    u_core.ret();
    m[1][3] = m[1][7];
    pm = (m[1][12:11] == 2'b11);
    #1;
    `CHK(resume_pc, m[3])
    `CHK(priv_machine, pm)
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] x;
    x = $urandom(32'h8694);
    foreach (m[i]) m[i] = ZERO;
    foreach (tc[i]) tc[i] = ZERO;
    foreach (tm[i]) tm[i] = ZERO;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    for (int a = 0; a <= 'h3C; a += 4) rd(a[7:0]);
    for (int i = 0; i < 3; i++) begin
      wr(8'h08, $urandom());
      rd(8'h08);
      wr(8'h34, $urandom());
      rd(8'h34);
      wr(8'h38, $urandom());
      rd(8'h38);
    end
    wr(8'h00, ONES);
    rd(8'h00);
    wr(8'h18, ONES);
    rd(8'h18);
    wr(8'h24, ONES);
    rd(8'h24);
    u_core.set_dbg(1'b1);
    wr(8'h24, $urandom());
    wr(8'h28, $urandom());
    rd(8'h24);
    rd(8'h28);
    wr(8'h1C, ONES);
    rd(8'h1C);
    u_core.set_dbg(1'b0);
    wr(8'h1C, ZERO);
    rd(8'h1C);
    u_core.set_dbg(1'b1);
    wr(8'h1C, ZERO);
    ha[0] = $urandom();
    ma[0] = ha[0] ^ 32'h0000_0001;
    x = $urandom() & 32'hFFFF_FFE0;
    ha[1] = x | 32'h0000_0013;
    ma[1] = x ^ 32'h0000_0020;
    ha[2] = $urandom();
    ma[2] = ha[2] ^ 32'h8000_0000;
    for (int k = 0; k < 3; k++) begin
      wr(8'h18, 32'(k));
      wr(8'h1C, (k == 1) ? 32'h0000_10C2 : (32'h0000_0040 | (32'h0000_0004 >> k)));
      wr(8'h20, (k == 1) ? (x | 32'h0000_000F) : ha[k]);
      rd(8'h1C);
      rd(8'h20);
    end
    u_core.set_dbg(1'b0);
    for (int k = 0; k < 3; k++) begin
      u_core.acc(k, ha[k]);
      #1;
      `CHK({bp_exception, debug_request}, fire(k, ha[k]))
      @(posedge clk);
      #1;
      `CHK({bp_exception, debug_request}, 2'b00)
      u_core.acc(k, ma[k]);
      #1;
      `CHK({bp_exception, debug_request}, fire(k, ma[k]))
    end
    for (int c = 0; c < 3; c++) begin
      x = $urandom();
      u_core.dent(c[1:0], x, x + 32'h0000_0004);
      #1;
      `CHK(debug_resume_pc, (c == 0) ? x : x + 32'h0000_0004)
    end
    wr(8'h04, 32'h0000_0008);
    take_trap(1'b0);
    take_trap(1'b1);
    x = $urandom();
    wr(8'h0C, x);
    wr(8'h04, 32'h0000_1880);
    take_ret();
    `CHK(resume_pc, x)
    rd(8'h30);
    wr(8'h04, ZERO);
    take_ret();
    wr(8'h08, ONES);
    rd(8'h08);
    u_core.acc(0, ha[0]);
    #1;
    `CHK({bp_exception, debug_request}, fire(0, ha[0]))
    wr(8'h30, 32'h0000_0008);
    rd(8'h30);
    u_core.set_lv(1'b1, 1'b1);
    @(posedge clk);
    #1;
    `CHK({irq_take, nmi_take}, 2'b11)
    wr(8'h30, ZERO);
    @(posedge clk);
    #1;
    `CHK({irq_take, nmi_take}, 2'b01)
    end_of_test();
  end
endmodule
`default_nettype wire
